// *** design/niw_map.svh ***
// Behaviour
// - enable register: ext0 b3, timer b2, ext1 b1, port b0
// - both flag registers read/write; reset clears them
// - request and enable both set activate vector
// - taking pushes pc and carry, jumps vector
// - taking clears all enables; re-enable to retake
// - enable write delays service two instructions
// - ext0 on port a bit 0, ext1 bit 3
// - rising select: low-to-high sets request, re-arm low
// - falling select: high-to-low sets request, re-arm high
// - timer wrap sets timer request flag
// - only input pins of ports b, c count
// - port falling: any pin falls, re-arm all high
// - port rising: any pin rises, re-arm all low
// - halt stops cpu; any interrupt wakes
// - stop wakes on ext, port or watchdog
// - config: ext edge b0, port edge b1, pull b2/b3
// - stop wake holds for 4096-clock warm-up
`ifndef NIW_MAP_SVH
`define NIW_MAP_SVH

// register indices; byte address is four times the index
`define NIW_IDX_ENABLE   8'h00
`define NIW_IDX_REQUEST  8'h01
`define NIW_IDX_CONFIG   8'h19
`define NIW_ADDR_LSB     2

// flag bit positions inside the enable and request registers
`define NIW_BIT_EXT0     3
`define NIW_BIT_TIMER    2
`define NIW_BIT_EXT1     1
`define NIW_BIT_PORT     0

// reset values
`define NIW_RST_FLAGS    4'h0
`define NIW_RST_CONFIG   4'h4

// service vectors, one per source
`define NIW_VEC_EXT0     12'h008
`define NIW_VEC_TIMER    12'h00c
`define NIW_VEC_EXT1     12'h010
`define NIW_VEC_PORT     12'h014

// timing counts in system clocks / instructions
`define NIW_EN_DELAY     2'h2
`define NIW_WARMUP_CLKS  13'h1000
`define NIW_WARMUP_LAST  13'h0fff

// hardware stack
`define NIW_STACK_DEPTH  4

`endif

// *** design/niw_pkg.sv ***
package niw_pkg;

   // power mode of the core as seen by the wake logic
   typedef enum logic [1:0] {
      NIW_RUN,
      NIW_HALT,
      NIW_STOP,
      NIW_WARM
   } niw_mode_t;

   // one hardware stack entry
   typedef struct packed {
      logic [11:0] pc;
      logic        carry;
   } niw_stack_entry_t;

   // one bit per source, bit order as in the flag registers
   typedef struct packed {
      logic ext0;
      logic timer;
      logic ext1;
      logic port;
   } niw_src_t;

   // port configuration register layout
   typedef struct packed {
      logic pull_enable;
      logic pull_direction_select;
      logic port_edge_select;
      logic external_edge_select;
   } niw_cfg_t;

   // port b and c pin group: level and direction (1 = output)
   typedef struct packed {
      logic [3:0] port_b_inputs;
      logic [3:0] port_c_inputs;
      logic [3:0] port_b_dir;
      logic [3:0] port_c_dir;
   } niw_ports_t;

endpackage : niw_pkg

// *** design/niw_stack.sv ***
`include "niw_map.svh"

module niw_stack (
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   // push and pop strobes
   input  wire logic                      push,
   input  wire logic                      pop,
   input  wire niw_pkg::niw_stack_entry_t wdata,
   // registered top of stack after a pop
   output niw_pkg::niw_stack_entry_t      rdata,
   output logic [2:0]                     depth
);
   import niw_pkg::*;

   niw_stack_entry_t mem_r [`NIW_STACK_DEPTH];
   logic [1:0]       sp_r;
   logic [2:0]       depth_r;
   wire  [1:0]       sp_dec = sp_r - 2'h1;

   // storage; a push on a full stack overwrites the oldest level, as on the core
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[sp_r] <= wdata;
      end
   end

   // pointer, depth and registered read data
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sp_r    <= 2'h0;
         depth_r <= 3'h0;
         rdata   <= '0;
      end else if (push) begin
         sp_r    <= sp_r + 2'h1;
         depth_r <= (depth_r == 3'h4) ? depth_r : depth_r + 3'h1;
      end else if (pop) begin
         sp_r    <= sp_dec;
         depth_r <= (depth_r == 3'h0) ? depth_r : depth_r - 3'h1;
         rdata   <= mem_r[sp_dec];
      end
   end

   assign depth = depth_r;

endmodule : niw_stack

// *** design/niw_intc.sv ***
`include "niw_map.svh"

module niw_intc (
   // clock and reset
   input  wire logic                      hclk,
   input  wire logic                      hresetn,
   // ahb-lite slave
   input  wire logic                      hsel,
   input  wire logic [31:0]               haddr,
   input  wire logic [1:0]                htrans,
   input  wire logic                      hwrite,
   input  wire logic [2:0]                hsize,
   input  wire logic [31:0]               hwdata,
   input  wire logic                      hready,
   output logic [31:0]                    hrdata,
   output logic                           hreadyout,
   output logic                           hresp,
   // interrupt pins and timer
   input  wire logic                      ext0_pin,
   input  wire logic                      ext1_pin,
   input  wire niw_pkg::niw_ports_t       ports,
   input  wire logic                      timer_event_input,
   input  wire logic                      wdt_overflow,
   // processor core
   input  wire logic                      instr_retire,
   input  wire logic                      halt_cmd,
   input  wire logic                      stop_cmd,
   input  wire logic                      call_push,
   input  wire logic                      ret_pop,
   input  wire logic [11:0]               cpu_pc,
   input  wire logic                      carry_flag,
   output logic                           irq_take,
   output logic [11:0]                    irq_vector,
   output niw_pkg::niw_stack_entry_t      restore,
   output logic [2:0]                     stack_depth,
   output logic                           cpu_run,
   output logic                           osc_run,
   // pull control towards the pads
   output logic                           pull_enable,
   output logic                           pull_direction_select
);
   import niw_pkg::*;

   // ------------------------------------------------------------------
   // bus slave: one wait state per transfer so that a read right after
   // a write never sees a stale register value
   // ------------------------------------------------------------------
   logic       dph_r;
   logic       dph_write_r;
   logic [7:0] dph_idx_r;

   wire ahb_go   = hsel & hready & htrans[1];
   wire dph_act  = dph_r & ~hreadyout;

   // address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_r       <= 1'b0;
         dph_write_r <= 1'b0;
         dph_idx_r   <= 8'h00;
      end else begin
         dph_r <= ahb_go;
         if (ahb_go) begin
            dph_write_r <= hwrite;
            dph_idx_r   <= haddr[`NIW_ADDR_LSB +: 8];
         end
      end
   end

   // register select; unmapped offsets read zero and drop writes
   wire sel_en  = (dph_idx_r == `NIW_IDX_ENABLE);
   wire sel_req = (dph_idx_r == `NIW_IDX_REQUEST);
   wire sel_cfg = (dph_idx_r == `NIW_IDX_CONFIG);
   wire wr_act  = dph_act & dph_write_r;
   wire rd_act  = dph_act & ~dph_write_r;
   wire wr_en   = wr_act & sel_en;
   wire wr_req  = wr_act & sel_req;
   wire wr_cfg  = wr_act & sel_cfg;
   wire [3:0] wdata4 = hwdata[3:0];

   // ------------------------------------------------------------------
   // register state
   // ------------------------------------------------------------------
   niw_src_t en_r;
   niw_src_t en_nxt;
   niw_src_t req_r;
   niw_src_t req_nxt;
   niw_src_t req_set;
   niw_cfg_t cfg_r;
   niw_cfg_t cfg_nxt;

   // read multiplexer, narrow data in the low bits
   wire [3:0] rd_mux = sel_en  ? en_r  :
                       sel_req ? req_r :
                       sel_cfg ? cfg_r : 4'h0;

   // ready, response and read data all from flops
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0000_0000;
      end else begin
         hresp <= 1'b0;
         if (ahb_go) begin
            hreadyout <= 1'b0;
         end else if (dph_r) begin
            hreadyout <= 1'b1;
         end
         if (rd_act) begin
            hrdata <= {28'h000_0000, rd_mux};
         end
      end
   end

   // ------------------------------------------------------------------
   // external pins: plain edge detect, which re-arms only once the pin
   // has gone back to its idle level
   // ------------------------------------------------------------------
   logic ext0_prev_r;
   logic ext1_prev_r;
   logic pins_seen_r;

   // no edge is reported on the first cycle after reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext0_prev_r <= 1'b0;
         ext1_prev_r <= 1'b0;
         pins_seen_r <= 1'b0;
      end else begin
         ext0_prev_r <= ext0_pin;
         ext1_prev_r <= ext1_pin;
         pins_seen_r <= 1'b1;
      end
   end

   wire ext_rise = cfg_r.external_edge_select;
   wire ext0_evt = pins_seen_r & (ext_rise ? (ext0_pin & ~ext0_prev_r)
                                           : (~ext0_pin & ext0_prev_r));
   wire ext1_evt = pins_seen_r & (ext_rise ? (ext1_pin & ~ext1_prev_r)
                                           : (~ext1_pin & ext1_prev_r));

   // ------------------------------------------------------------------
   // port b/c: output pins are forced to the idle level so they never
   // trigger; one request per excursion of the whole group
   // ------------------------------------------------------------------
   logic port_armed_r;

   wire [7:0] port_lvl = {ports.port_b_inputs, ports.port_c_inputs};
   wire [7:0] port_out = {ports.port_b_dir, ports.port_c_dir};
   wire       port_rise = cfg_r.port_edge_select;
   wire [7:0] port_fall_view = port_lvl | port_out;
   wire [7:0] port_rise_view = port_lvl & ~port_out;
   wire       port_idle = port_rise ? ~|port_rise_view
                                    : &port_fall_view;
   wire       port_evt  = port_armed_r & ~port_idle;

   // arm when every input sits at idle, disarm on the triggering change
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         port_armed_r <= 1'b0;
      end else begin
         port_armed_r <= port_idle;
      end
   end

   // ------------------------------------------------------------------
   // request and enable flags; a hardware event wins over a software
   // clear in the same cycle
   // ------------------------------------------------------------------
   assign req_set = '{ext0:  ext0_evt,
                      timer: timer_event_input,
                      ext1:  ext1_evt,
                      port:  port_evt};

   // taking an interrupt leaves the requests alone
   assign req_nxt = (wr_req ? niw_src_t'(wdata4) : req_r) | req_set;

   // a bus write to the enables in the take cycle holds the take off
   logic take;
   assign en_nxt = wr_en ? niw_src_t'(wdata4) :
                   take  ? niw_src_t'(`NIW_RST_FLAGS) : en_r;

   assign cfg_nxt = wr_cfg ? niw_cfg_t'(wdata4) : cfg_r;

   // flag registers, all zero after reset; config resets to 4'h4
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         en_r  <= niw_src_t'(`NIW_RST_FLAGS);
         req_r <= niw_src_t'(`NIW_RST_FLAGS);
         cfg_r <= niw_cfg_t'(`NIW_RST_CONFIG);
      end else begin
         en_r  <= en_nxt;
         req_r <= req_nxt;
         cfg_r <= cfg_nxt;
      end
   end

   // ------------------------------------------------------------------
   // enable delay: after any enable write the core retires two more
   // instructions before a take; the take is simply lost if those
   // instructions clear the enable or the request
   // ------------------------------------------------------------------
   logic [1:0] delay_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         delay_r <= 2'h0;
      end else if (wr_en) begin
         delay_r <= `NIW_EN_DELAY;
      end else if (instr_retire && delay_r != 2'h0) begin
         delay_r <= delay_r - 2'h1;
      end
   end

   // ------------------------------------------------------------------
   // activation and fixed priority
   // ------------------------------------------------------------------
   niw_mode_t mode_r;
   niw_mode_t mode_nxt;

   wire [3:0] active   = en_r & req_r;
   wire       any_act  = |active;
   wire       src_ext0 = active[`NIW_BIT_EXT0];
   wire       src_tmr  = active[`NIW_BIT_TIMER];
   wire       src_ext1 = active[`NIW_BIT_EXT1];

   // ext0 first, then timer, then ext1, then port
   wire [11:0] vec_sel = src_ext0 ? `NIW_VEC_EXT0  :
                         src_tmr  ? `NIW_VEC_TIMER :
                         src_ext1 ? `NIW_VEC_EXT1  : `NIW_VEC_PORT;

   // takes happen only at an instruction boundary of a running core
   assign take = any_act & (delay_r == 2'h0) & instr_retire
               & (mode_r == NIW_RUN) & ~wr_en;

   // vector handed to the core, one pulse per take
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_take   <= 1'b0;
         irq_vector <= 12'h000;
      end else begin
         irq_take <= take;
         if (take) begin
            irq_vector <= vec_sel;
         end
      end
   end

   // ------------------------------------------------------------------
   // hardware stack: pc and carry go in on a take; nesting is limited
   // only by the four levels shared with subroutine calls
   // ------------------------------------------------------------------
   niw_stack_entry_t push_data;

   assign push_data = '{pc: cpu_pc, carry: carry_flag};

   niw_stack u_stack (
      .clk   (hclk),
      .rst_n (hresetn),
      .push  (take | call_push),
      .pop   (ret_pop),
      .wdata (push_data),
      .rdata (restore),
      .depth (stack_depth)
   );

   // ------------------------------------------------------------------
   // halt, stop and warm-up
   // ------------------------------------------------------------------
   logic [12:0] warm_cnt_r;

   // stop wakes on raw pin and port events, enabled or not
   wire stop_wake = ext0_evt | ext1_evt | port_evt | wdt_overflow;
   wire warm_done = (warm_cnt_r == `NIW_WARMUP_LAST);

   // power mode sequencer
   always_comb begin
      mode_nxt = mode_r;
      case (mode_r)
         NIW_RUN: begin
            if (stop_cmd) begin
               mode_nxt = NIW_STOP;
            end else if (halt_cmd) begin
               mode_nxt = NIW_HALT;
            end
         end
         NIW_HALT: begin
            if (any_act) begin
               mode_nxt = NIW_RUN;
            end
         end
         NIW_STOP: begin
            if (stop_wake) begin
               mode_nxt = NIW_WARM;
            end
         end
         NIW_WARM: begin
            if (warm_done) begin
               mode_nxt = NIW_RUN;
            end
         end
         default: begin
            mode_nxt = NIW_RUN;
         end
      endcase
   end

   // mode state and the run strobes seen by the core and the oscillator
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_r  <= NIW_RUN;
         cpu_run <= 1'b1;
         osc_run <= 1'b1;
      end else begin
         mode_r  <= mode_nxt;
         cpu_run <= (mode_nxt == NIW_RUN);
         osc_run <= (mode_nxt != NIW_STOP);
      end
   end

   // warm-up counter only runs while waiting for the oscillator
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         warm_cnt_r <= 13'h0000;
      end else if (mode_r == NIW_WARM) begin
         warm_cnt_r <= warm_cnt_r + 13'h0001;
      end else begin
         warm_cnt_r <= 13'h0000;
      end
   end

   // pad pull controls in their own flops, loaded from the config next value
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pull_enable           <= 1'b0;
         pull_direction_select <= 1'b1;
      end else begin
         pull_enable           <= cfg_nxt.pull_enable;
         pull_direction_select <= cfg_nxt.pull_direction_select;
      end
   end

endmodule : niw_intc

// *** tb/niw_intc_properties.sv ***
module niw_intc_properties (
   // clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // bus handshake
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hready,
   input wire logic        hreadyout,
   // core side
   input wire logic        instr_retire,
   input wire logic        halt_cmd,
   input wire logic        stop_cmd,
   input wire logic        irq_take,
   input wire logic [11:0] irq_vector,
   input wire logic [2:0]  stack_depth,
   input wire logic        cpu_run,
   input wire logic        osc_run
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_one_wait: assert property (hsel & htrans[1] & hready |=> !hreadyout ##1 hreadyout)
      else $error("wait state count");
   a_take_retire: assert property ($rose(irq_take) |-> $past(instr_retire & cpu_run))
      else $error("take off retire");
   a_take_single: assert property (irq_take |=> !irq_take)
      else $error("double take");
   a_vector_known: assert property (irq_take |-> irq_vector inside
                                    {12'h008, 12'h00c, 12'h010, 12'h014})
      else $error("bad vector");
   a_take_push: assert property (irq_take |-> stack_depth == $past(stack_depth) + 3'h1
                                 || $past(stack_depth) == 3'h4)
      else $error("no push");
   a_halt_stops: assert property (cpu_run && halt_cmd && !stop_cmd |=> !cpu_run)
      else $error("halt ignored");
   a_stop_sleeps: assert property (cpu_run && stop_cmd |=> !osc_run && !cpu_run)
      else $error("stop ignored");
   a_stop_no_cpu: assert property (!osc_run |-> !cpu_run)
      else $error("core without oscillator");
   a_warm_hold: assert property ($rose(osc_run) |-> (!cpu_run) [*8])
      else $error("run in warm-up");

   c_take: cover property (irq_take);
   c_stop: cover property ($fell(osc_run));
   c_wake: cover property ($rose(cpu_run));
endmodule : niw_intc_properties

bind niw_intc niw_intc_properties u_niw_intc_properties (.*);

// *** tb/niw_core_model.sv ***
module niw_core_model (
   // clock and reset
   input wire logic         hclk,
   input wire logic         hresetn,
   // pacing from the bench
   input wire logic         go,
   input wire logic [3:0]   gap,
   // design side
   input wire logic         cpu_run,
   input wire logic         irq_take,
   input wire logic [11:0]  irq_vector,
   output logic             instr_retire,
   output logic [11:0]      cpu_pc,
   output logic             carry_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt_r;

   // one instruction per gap+1 cycles; a halted core retires nothing
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {cnt_r, instr_retire, carry_flag} <= '0;
         cpu_pc <= 12'h100;
      end else begin
         instr_retire <= 1'b0;
         if (irq_take) begin
            cpu_pc <= irq_vector;
            cnt_r <= 4'h0;
         end else if (go && cpu_run) begin
            cnt_r <= (cnt_r >= gap) ? 4'h0 : cnt_r + 4'h1;
            if (cnt_r >= gap) begin
               instr_retire <= 1'b1;
               cpu_pc <= cpu_pc + 12'h1;
               carry_flag <= ~carry_flag;
            end
         end
      end
   end
endmodule : niw_core_model

// *** tb/niw_intc_tb_top.sv ***
`include "niw_map.svh"

module niw_intc_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import niw_pkg::*;

   logic             hclk, hresetn, hsel, hwrite, hreadyout, hresp, go;
   logic [31:0]      haddr, hwdata, hrdata, rd;
   logic [1:0]       htrans;
   logic [2:0]       hsize, stack_depth;
   logic             ext0_pin, ext1_pin, timer_event_input, wdt_overflow, halt_cmd, stop_cmd;
   logic             instr_retire, ret_pop, carry_flag, irq_take, cpu_run, osc_run;
   logic             pull_enable, pull_direction_select, take_cy, cy_prev;
   logic [11:0]      cpu_pc, irq_vector, take_pc, pc_prev;
   logic [3:0]       gap;
   niw_ports_t       pins;
   niw_stack_entry_t restore;
   int               n_fail, checks_done, n_ret, n_take, ret_at;

   always #2 hclk = ~hclk;

   niw_intc u_niw_intc (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ext0_pin, .ext1_pin, .ports(pins),
      .timer_event_input, .wdt_overflow, .instr_retire, .halt_cmd, .stop_cmd,
      .call_push(1'b0), .ret_pop, .cpu_pc, .carry_flag, .irq_take, .irq_vector, .restore,
      .stack_depth, .cpu_run, .osc_run, .pull_enable, .pull_direction_select);
   niw_core_model u_niw_core_model (.hclk, .hresetn, .go, .gap, .cpu_run, .irq_take,
      .irq_vector, .instr_retire, .cpu_pc, .carry_flag);

   // records each take
   always @(posedge hclk) begin
      if (irq_take) begin
         n_take++;
         ret_at = n_ret;
         take_pc = pc_prev;
         take_cy = cy_prev;
      end
      if (instr_retire) n_ret++;
      pc_prev = cpu_pc;
      cy_prev = carry_flag;
   end

   task automatic test_done;
      if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : test_done

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask : cyc

   // single word transfer; called just after a rising edge
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [3:0] wd);
      int n = 0;
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= wr;
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 40);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {28'h0, wd};
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 40);
      rd = hrdata;
      if (n >= 40) begin n_fail++; test_done(); end
   endtask : bus

   task automatic rchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 4'h0);
      chk(what, exp, {hresp, rd[30:0]});
   endtask : rchk

   task automatic drive(input logic [4:0] v);
      {ret_pop, halt_cmd, stop_cmd, wdt_overflow, timer_event_input} <= v;
      cyc(1);
   endtask : drive

   task automatic wait_take(input int want);
      for (int n = 0; n < 200 && n_take < want; n++) @(posedge hclk);
      if (n_take < want) begin n_fail++; test_done(); end
   endtask : wait_take

   task automatic wait_run(output int n);
      for (n = 0; n < 5000 && cpu_run !== 1'b1; n++) @(posedge hclk);
      if (cpu_run !== 1'b1) begin n_fail++; test_done(); end
   endtask : wait_run

   // reset values, read back, unmapped hole
   task automatic t_regs;
      rchk("enable rst", `NIW_IDX_ENABLE, 32'h0);
      rchk("request rst", `NIW_IDX_REQUEST, 32'h0);
      rchk("config rst", `NIW_IDX_CONFIG, 32'h4);
      chk("pulls rst", 32'h1, {30'h0, pull_enable, pull_direction_select});
      bus(1'b1, `NIW_IDX_ENABLE, 4'ha);
      rchk("enable rw", `NIW_IDX_ENABLE, 32'ha);
      bus(1'b1, `NIW_IDX_REQUEST, 4'h5);
      rchk("request rw", `NIW_IDX_REQUEST, 32'h5);
      bus(1'b1, 8'h02, 4'hf);
      rchk("unmapped", 8'h02, 32'h0);
      bus(1'b1, `NIW_IDX_ENABLE, 4'h0);
      bus(1'b1, `NIW_IDX_REQUEST, 4'h0);
   endtask : t_regs

   // both external pins, falling then rising select
   task automatic t_ext;
      ext0_pin <= 1'b0;
      ext1_pin <= 1'b0;
      rchk("ext fall", `NIW_IDX_REQUEST, 32'ha);
      bus(1'b1, `NIW_IDX_REQUEST, 4'h0);
      bus(1'b1, `NIW_IDX_CONFIG, 4'h9);
      chk("pulls low", 32'h2, {30'h0, pull_enable, pull_direction_select});
      ext0_pin <= 1'b1;
      rchk("ext0 rise", `NIW_IDX_REQUEST, 32'h8);
      bus(1'b1, `NIW_IDX_REQUEST, 4'h0);
      ext1_pin <= 1'b1;
      rchk("ext1 rise", `NIW_IDX_REQUEST, 32'h2);
      bus(1'b1, `NIW_IDX_REQUEST, 4'h0);
      ext0_pin <= 1'b0;
      rchk("ext0 fall ignored", `NIW_IDX_REQUEST, 32'h0);
      bus(1'b1, `NIW_IDX_CONFIG, 4'h4);
   endtask : t_ext

   // port b/c group: outputs ignored, one shot until idle again
   task automatic t_port;
      pins.port_b_dir[0] <= 1'b1;
      pins.port_b_inputs[0] <= 1'b0;
      rchk("port output pin", `NIW_IDX_REQUEST, 32'h0);
      pins.port_c_inputs[2] <= 1'b0;
      rchk("port fall", `NIW_IDX_REQUEST, 32'h1);
      bus(1'b1, `NIW_IDX_REQUEST, 4'h0);
      pins.port_b_inputs[3] <= 1'b0;
      rchk("port not rearmed", `NIW_IDX_REQUEST, 32'h0);
      pins.port_b_inputs <= 4'h0;
      pins.port_c_inputs <= 4'h0;
      bus(1'b1, `NIW_IDX_CONFIG, 4'h6);
      bus(1'b1, `NIW_IDX_REQUEST, 4'h0);
      pins.port_c_inputs[0] <= 1'b1;
      rchk("port rise", `NIW_IDX_REQUEST, 32'h1);
      bus(1'b1, `NIW_IDX_REQUEST, 4'h0);
      pins.port_c_inputs[1] <= 1'b1;
      rchk("port rise rearm", `NIW_IDX_REQUEST, 32'h0);
      pins <= {4'hf, 4'hf, 4'h0, 4'h0};
      bus(1'b1, `NIW_IDX_CONFIG, 4'h4);
      bus(1'b1, `NIW_IDX_REQUEST, 4'h0);
   endtask : t_port

   // timer take after the enable delay, return, and a dropped take
   task automatic t_take;
      int k = n_take;
      drive(5'h01);
      drive(5'h00);
      rchk("timer request", `NIW_IDX_REQUEST, 32'h4);
      bus(1'b1, `NIW_IDX_ENABLE, 4'h4);
      n_ret = 0;
      go <= 1'b1;
      wait_take(k + 1);
      go <= 1'b0;
      chk("retires to take", 32'd3, ret_at);
      chk("timer vector", {20'h0, `NIW_VEC_TIMER}, {20'h0, irq_vector});
      rchk("enables cleared", `NIW_IDX_ENABLE, 32'h0);
      rchk("request kept", `NIW_IDX_REQUEST, 32'h4);
      drive(5'h10);
      drive(5'h00);
      chk("saved pc carry", {19'h0, take_pc, take_cy}, {19'h0, restore});
      chk("depth after pop", 32'h0, {29'h0, stack_depth});
      bus(1'b1, `NIW_IDX_ENABLE, 4'h4);
      n_ret = 0;
      go <= 1'b1;
      for (int n = 0; n < 50 && n_ret < 1; n++) @(posedge hclk);
      go <= 1'b0;
      bus(1'b1, `NIW_IDX_REQUEST, 4'h0);
      go <= 1'b1;
      cyc(30);
      go <= 1'b0;
      chk("dropped take", k + 1, n_take);
   endtask : t_take

   // all sources pending: order, vectors, nesting depth
   task automatic t_prio;
      logic [3:0]  msk[5] = '{4'hf, 4'h7, 4'h3, 4'h1, 4'hf};
      logic [11:0] vec[5] = '{`NIW_VEC_EXT0, `NIW_VEC_TIMER, `NIW_VEC_EXT1, `NIW_VEC_PORT,
                              `NIW_VEC_EXT0};
      int          k = n_take;
      bus(1'b1, `NIW_IDX_REQUEST, 4'hf);
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, `NIW_IDX_ENABLE, msk[i]);
         go <= 1'b1;
         wait_take(k + i + 1);
         go <= 1'b0;
         chk("vector", {20'h0, vec[i]}, {20'h0, irq_vector});
         chk("depth", 32'((i < 4) ? i + 1 : 4), {29'h0, stack_depth});
      end
      bus(1'b1, `NIW_IDX_REQUEST, 4'h0);
   endtask : t_prio

   // halt wake by timer, stop wake by pin and watchdog, warm-up length
   task automatic t_sleep;
      int n;
      bus(1'b1, `NIW_IDX_ENABLE, 4'h4);
      drive(5'h08);
      drive(5'h00);
      cyc(1);
      chk("halted", 32'h0, {31'h0, cpu_run});
      drive(5'h01);
      drive(5'h00);
      wait_run(n);
      chk("halt wake", 32'h1, 32'(n < 10));
      bus(1'b1, `NIW_IDX_ENABLE, 4'h0);
      bus(1'b1, `NIW_IDX_REQUEST, 4'h0);
      drive(5'h04);
      drive(5'h01);
      drive(5'h00);
      cyc(2);
      chk("timer no stop wake", 32'h0, {31'h0, osc_run});
      ext1_pin <= 1'b0;
      cyc(3);
      chk("pin wake osc", 32'h1, {31'h0, osc_run});
      wait_run(n);
      chk("warm-up", 32'h1, 32'(n > 4088 && n < 4104));
      drive(5'h04);
      drive(5'h02);
      drive(5'h00);
      wait_run(n);
      chk("wdt wake", 32'h1, 32'(n > 4088 && n < 4104));
   endtask : t_sleep

   // reset for six cycles, then the scenarios in turn
   initial begin
      {hclk, hresetn, hsel, haddr, htrans, hwrite, hwdata, timer_event_input} = '0;
      {wdt_overflow, halt_cmd, stop_cmd, ret_pop, go, ext0_pin, ext1_pin} = 7'b0000011;
      hsize = 3'h2;
      gap = 4'h2;
      pins = {4'hf, 4'hf, 4'h0, 4'h0};
      cyc(6);
      hresetn <= 1'b1;
      cyc(2);
      t_regs();
      t_ext();
      t_port();
      t_take();
      t_prio();
      t_sleep();
      test_done();
   end
endmodule : niw_intc_tb_top
